// ### logic/mdd_decoder.sv
// Memory map and operating mode decoder with an APB register port
//
// Operation
// RQ1 - No option jumper fitted selects the flash code architecture.
// RQ2 - Flash code: fetches go to 64K flash, data to separate 64K RAM.
// RQ3 - Only the top option jumper fitted selects the RAM resident architecture.
// RQ4 - RAM resident: flash unused; code in one 64K RAM half, data other.
// RQ5 - Option jumpers 0 and 1 fitted select the overlapped monitor architecture.
// RQ6 - Overlapped: 32K monitor plus 32K RAM form one shared 64K space.
// RQ7 - Overlapped program mode: monitor low half, RAM at 8000h to FFFFh.
// RQ8 - Overlapped run mode: halves swap, RAM low, monitor high.
// RQ9 - Run mode under flash code or RAM resident: program answers at address 0.
// RQ10 - Red indicator lit in program mode, dark once run mode entered.
// RQ11 - Green indicator lit whenever the board is in run mode.
// RQ12 - External access option and port driven option inputs are ignored; the code uses port inputs 0 and 1 once software sets the port enable bit.
// RQ13 - Slide switch sampled only at a reset event, held until the next; the code also resamples it on a software recapture.
// RQ14 - Unlisted option combinations decode as the flash code architecture.
`timescale 1ns/1ns
module mdd_decoder
  import mdd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mdd_apb_req_t apb_req,
  output mdd_apb_rsp_t apb_rsp,
  input wire mdd_cpu_bus_t cpu_bus,
  input wire logic [4:0] option_jumper_inputs_n,
  input wire logic [3:0] port_driven_option_inputs,
  input wire logic mode_slide_switch,
  output mdd_mem_sel_t mem_sel,
  output logic led_red,
  output logic led_green
);

  // ************************************************************
  // Functions
  // ************************************************************

  // Turn fitted option positions into an architecture
  // Bit 0 is the top position, bit 1 the next one down
  function automatic mdd_arch_t decode_arch(input logic [1:0] fitted);
    mdd_arch_t arch;
    arch = MDD_FLASH_CODE_ARCH;
    case (fitted)
      2'b00: arch = MDD_FLASH_CODE_ARCH; // [RQ1]
      2'b01: arch = MDD_RAM_RESIDENT_ARCH; // [RQ3]
      2'b11: arch = MDD_OVERLAPPED_MONITOR_ARCH; // [RQ5]
      default: arch = MDD_FLASH_CODE_ARCH; // [RQ14]
    endcase
    return arch;
  endfunction

  // Steer one bus access to flash or RAM, with the physical bank bits
  // Chip selects are active low; both stay high when nothing is chosen
  function automatic mdd_mem_sel_t map_access(
    input mdd_arch_t arch,
    input logic run,
    input logic is_code,
    input logic [15:0] addr
  );
    mdd_mem_sel_t sel;
    logic upper;
    sel = '{flash_ce_n: 1'b1, ram_ce_n: 1'b1, mem_a16: 1'b0, mem_a15: addr[MDD_HALF_BIT]};
    upper = addr[MDD_HALF_BIT];
    case (arch)
      MDD_RAM_RESIDENT_ARCH: begin
        // Code in the low RAM half, data in the high half; address 0 is code
        sel.ram_ce_n = 1'b0; // [RQ4] [RQ9]
        sel.mem_a16 = !is_code; // [RQ4]
      end
      MDD_OVERLAPPED_MONITOR_ARCH: begin
        // Same map for code and data; run mode swaps the halves
        if (upper == run) begin
          sel.flash_ce_n = 1'b0; // [RQ6] [RQ7] [RQ8]
        end else begin
          sel.ram_ce_n = 1'b0; // [RQ6] [RQ7] [RQ8]
        end
        // Each 32K half lands at the bottom of its device
        sel.mem_a15 = 1'b0; // [RQ6]
      end
      default: begin
        // Flash code: fetches to flash, data to RAM, both from 0
        if (is_code) begin
          sel.flash_ce_n = 1'b0; // [RQ2] [RQ9]
        end else begin
          sel.ram_ce_n = 1'b0; // [RQ2]
        end
      end
    endcase
    return sel;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************

  // Every jumper, port option and switch pin is asynchronous to pclk, so each passes four flip-flops
  logic [4:0] jumper_n_sync;
  logic [3:0] port_sync;
  logic switch_sync;

  // Jumper pins pull to ground when fitted, so they idle high
  mdd_pin_sync #(
    .WIDTH(5),
    .RESET_VALUE(5'h1F)
  ) u_jumper_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(option_jumper_inputs_n),
    .level(jumper_n_sync)
  );

  // Port driven options idle low, so an unwired header reads as not fitted
  mdd_pin_sync #(
    .WIDTH(4),
    .RESET_VALUE(4'h0)
  ) u_port_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(port_driven_option_inputs),
    .level(port_sync)
  );

  // Switch resets to program mode, the safe state for a blank flash
  mdd_pin_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_switch_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(mode_slide_switch),
    .level(switch_sync)
  );

  // ************************************************************
  // Control register and option resolution
  // ************************************************************

  // Software options; both clear at every reset event
  logic port_opt_en;
  logic recapture;
  logic apb_write;
  logic apb_setup;
  logic [1:0] fitted;

  // Setup phase of a transfer; the access phase always finishes next cycle
  // A write lands only at the edge where the access phase sees pready
  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_write = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;

  // Control bits; the recapture bit is a one-cycle pulse and reads as zero
  // Writes to other offsets leave both bits alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_opt_en <= MDD_CTRL_RESET[MDD_CTRL_PORT_EN_BIT];
      recapture <= MDD_CTRL_RESET[MDD_CTRL_RECAP_BIT];
    end else begin
      recapture <= 1'b0;
      if (apb_write && apb_req.paddr == MDD_CTRL_OFS) begin
        port_opt_en <= apb_req.pwdata[MDD_CTRL_PORT_EN_BIT];
        recapture <= apb_req.pwdata[MDD_CTRL_RECAP_BIT];
      end
    end
  end

  // Only positions 0 and 1 count; position 4 and the port inputs are
  // dropped unless software opts the port inputs in for a custom build
  assign fitted = ~jumper_n_sync[1:0]
                | (port_opt_en ? port_sync[1:0] : 2'b00); // [RQ12]

  // ************************************************************
  // Reset event capture
  // ************************************************************

  // One-hot states keep the decode to a single bit per state
  mdd_cap_state_t cap_state;
  logic [1:0] settle_cnt;
  mdd_arch_t arch;
  logic run_mode;
  logic captured;
  logic [7:0] capture_count;

  // Wait for the synchronisers to fill, latch once, then hold.
  // The synchronisers show a settled pin only after their fourth edge,
  // so the count runs to the full settle figure before the latch state;
  // latching any sooner would read their reset levels instead of the pins.
  // The switch is never looked at in the hold state, so moving it does
  // nothing until the next reset event or a software recapture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_state <= MDD_CAP_SETTLE;
      settle_cnt <= 2'h0;
    end else begin
      case (cap_state)
        MDD_CAP_SETTLE: begin
          settle_cnt <= settle_cnt + 2'h1;
          if (settle_cnt == MDD_SETTLE_CYCLES) begin
            cap_state <= MDD_CAP_LATCH;
          end
        end
        MDD_CAP_LATCH: begin
          cap_state <= MDD_CAP_HOLD;
        end
        MDD_CAP_HOLD: begin
          if (recapture) begin
            cap_state <= MDD_CAP_SETTLE; // [RQ13]
            settle_cnt <= 2'h0;
          end
        end
        default: begin
          cap_state <= MDD_CAP_SETTLE;
          settle_cnt <= 2'h0;
        end
      endcase
    end
  end

  // Mode and architecture, taken only in the latch state
  // Jumpers are read together with the switch, so both share one event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arch <= MDD_FLASH_CODE_ARCH;
      run_mode <= 1'b0;
    end else if (cap_state == MDD_CAP_LATCH) begin
      arch <= decode_arch(fitted);
      run_mode <= (switch_sync == MDD_SWITCH_RUN_LEVEL); // [RQ13]
    end
  end

  // Memory stays deselected until the first latch has happened
  // A recapture drops it again so no access is steered by a stale map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured <= 1'b0;
    end else if (cap_state == MDD_CAP_LATCH) begin
      captured <= 1'b1;
    end else if (cap_state == MDD_CAP_SETTLE) begin
      captured <= 1'b0;
    end
  end

  // Latch events since the last reset, wrapping
  // Software can tell that a recapture happened without timing it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_count <= MDD_COUNT_RESET;
    end else if (cap_state == MDD_CAP_LATCH) begin
      capture_count <= capture_count + 8'h01;
    end
  end

  // ************************************************************
  // Memory selects and indicators
  // ************************************************************

  // The CPU bus shares pclk, so its strobes need no synchroniser
  logic access;
  logic is_code;
  mdd_mem_sel_t next_mem_sel;

  // A fetch wins over a data strobe if both are ever low together
  assign is_code = !cpu_bus.code_rd_n;
  assign access = is_code || !cpu_bus.data_rd_n || !cpu_bus.data_wr_n;

  // Decode each access; one register stage keeps outputs glitch free
  always_comb begin
    next_mem_sel = '{flash_ce_n: 1'b1, ram_ce_n: 1'b1, mem_a16: 1'b0, mem_a15: 1'b0};
    if (access && captured) begin
      next_mem_sel = map_access(arch, run_mode, is_code, cpu_bus.addr);
    end
  end

  // Selects idle high through reset so neither memory drives the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_sel <= '{flash_ce_n: 1'b1, ram_ce_n: 1'b1, mem_a16: 1'b0, mem_a15: 1'b0};
    end else begin
      mem_sel <= next_mem_sel;
    end
  end

  // Indicators follow the held mode, not the switch itself
  // The red and green lamps are always complementary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_red <= 1'b1;
      led_green <= 1'b0;
    end else begin
      led_red <= !run_mode; // [RQ10]
      led_green <= run_mode; // [RQ11]
    end
  end

  // ************************************************************
  // APB read path
  // ************************************************************

  // Reads are decoded from the setup address, one cycle ahead
  logic [31:0] next_rdata;
  logic next_err;

  // Read mux; unmapped addresses answer zero with an error
  // Unused bits stay zero so software may mask loosely
  always_comb begin
    next_rdata = MDD_ZERO_WORD;
    next_err = 1'b0;
    case (apb_req.paddr)
      MDD_CTRL_OFS: begin
        next_rdata[MDD_CTRL_PORT_EN_BIT] = port_opt_en;
      end
      MDD_STATUS_OFS: begin
        next_rdata[MDD_ST_ARCH_LSB +: 3] = arch;
        next_rdata[MDD_ST_RUN_BIT] = run_mode;
        next_rdata[MDD_ST_CAPT_BIT] = captured;
        next_rdata[MDD_ST_JMP_LSB +: 5] = ~jumper_n_sync;
        next_rdata[MDD_ST_PORT_LSB +: 4] = port_sync;
      end
      MDD_MAP_OFS: begin
        next_rdata[3:0] = mem_sel;
      end
      MDD_COUNT_OFS: begin
        next_rdata[7:0] = capture_count;
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // Response is built in the setup cycle and shown for the access cycle
  // Zero wait states: pready rises for exactly one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp <= '{prdata: MDD_ZERO_WORD, pready: 1'b0, pslverr: 1'b0};
    end else if (apb_setup) begin
      apb_rsp.prdata <= apb_req.pwrite ? MDD_ZERO_WORD : next_rdata;
      apb_rsp.pready <= 1'b1;
      apb_rsp.pslverr <= next_err;
    end else begin
      apb_rsp <= '{prdata: MDD_ZERO_WORD, pready: 1'b0, pslverr: 1'b0};
    end
  end

endmodule

// ### logic/mdd_pkg.sv
// Shared constants, types and register map of the memory map and mode decoder
package mdd_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int unsigned MDD_AW = 12;
  localparam int unsigned MDD_DW = 32;
  localparam int unsigned MDD_JMP_W = 5;
  localparam int unsigned MDD_PORT_W = 4;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] MDD_CTRL_OFS = 12'h000;
  localparam logic [11:0] MDD_STATUS_OFS = 12'h004;
  localparam logic [11:0] MDD_MAP_OFS = 12'h008;
  localparam logic [11:0] MDD_COUNT_OFS = 12'h00C;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned MDD_CTRL_PORT_EN_BIT = 0;
  localparam int unsigned MDD_CTRL_RECAP_BIT = 1;
  localparam logic [1:0] MDD_CTRL_RESET = 2'h0;
  localparam int unsigned MDD_ST_ARCH_LSB = 0;
  localparam int unsigned MDD_ST_RUN_BIT = 4;
  localparam int unsigned MDD_ST_CAPT_BIT = 5;
  localparam int unsigned MDD_ST_JMP_LSB = 8;
  localparam int unsigned MDD_ST_PORT_LSB = 16;
  localparam logic [7:0] MDD_COUNT_RESET = 8'h00;
  localparam logic [31:0] MDD_ZERO_WORD = 32'h0000_0000;

  // ************************************************************
  // Levels and timing
  // ************************************************************
  // Slide switch level that selects run mode
  localparam logic MDD_SWITCH_RUN_LEVEL = 1'b1;
  // Final settle count; the settle state lasts one cycle more while the pin synchronisers fill after a reset event
  localparam logic [1:0] MDD_SETTLE_CYCLES = 2'h3;
  // Address bit 15 splits the overlapped space into halves
  localparam int unsigned MDD_HALF_BIT = 15;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    MDD_FLASH_CODE_ARCH = 3'b001,
    MDD_RAM_RESIDENT_ARCH = 3'b010,
    MDD_OVERLAPPED_MONITOR_ARCH = 3'b100
  } mdd_arch_t;

  typedef enum logic [2:0] {
    MDD_CAP_SETTLE = 3'b001,
    MDD_CAP_LATCH = 3'b010,
    MDD_CAP_HOLD = 3'b100
  } mdd_cap_state_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } mdd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mdd_apb_rsp_t;

  typedef struct packed {
    logic [15:0] addr;
    logic code_rd_n;
    logic data_rd_n;
    logic data_wr_n;
  } mdd_cpu_bus_t;

  typedef struct packed {
    logic flash_ce_n;
    logic ram_ce_n;
    logic mem_a16;
    logic mem_a15;
  } mdd_mem_sel_t;

endpackage

// ### logic/mdd_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module mdd_pin_sync
  import mdd_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain; stage1 feeds only stage2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per bit, take the new value only when two settled stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= RESET_VALUE;
    end else begin
      level <= (stage2 & stage3) | (level & (stage2 | stage3));
    end
  end

endmodule

// ### verification/mdd_cpu_model.sv
// Behavioural model of the microcontroller external code and data bus
`timescale 1ns/1ns
module mdd_cpu_model
  import mdd_pkg::*;
(
  input wire logic pclk,
  output mdd_cpu_bus_t cpu_bus
);
  // ********
  // Bus cycles
  // ********
  // Bus starts idle, all strobes high
  initial begin
    cpu_bus = '{16'h0000, 1'b1, 1'b1, 1'b1};
  end
  // Kind 0 idle, 1 fetch, 2 data read, 3 data write
  task automatic cycle(input logic [1:0] kind, input logic [15:0] a);
    @(posedge pclk);
    cpu_bus.addr <= (kind == 2'd0) ? ~cpu_bus.addr : a; // Idle bus shows no stale address
    cpu_bus.code_rd_n <= (kind != 2'd1);
    cpu_bus.data_rd_n <= (kind != 2'd2);
    cpu_bus.data_wr_n <= (kind != 2'd3);
  endtask
endmodule

// ### verification/mdd_decoder_assertions.sv
// Port checker for the memory map and mode decoder
`timescale 1ns/1ns
module mdd_decoder_assertions
  import mdd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mdd_apb_req_t apb_req,
  input wire mdd_apb_rsp_t apb_rsp,
  input wire mdd_cpu_bus_t cpu_bus,
  input wire mdd_mem_sel_t mem_sel,
  input wire logic led_red,
  input wire logic led_green
);
  // ********
  // Helper logic
  // ********
  logic [3:0] since_evt;
  wire logic mapped = apb_req.paddr <= MDD_COUNT_OFS && apb_req.paddr[1:0] == 2'b00;
  // Cycles since a capture event; any write to the control offset restarts it too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_evt <= 4'h0;
    end else if (apb_req.psel && apb_req.pwrite && apb_req.paddr == MDD_CTRL_OFS) begin
      since_evt <= 4'h0;
    end else if (since_evt != 4'hF) begin
      since_evt <= since_evt + 4'h1;
    end
  end
  // ********
  // Properties
  // ********
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; apb_req.psel && !apb_req.penable; endsequence
  sequence answer_s; apb_req.psel && apb_req.penable && apb_rsp.pready; endsequence
  sequence idle_s; cpu_bus.code_rd_n && cpu_bus.data_rd_n && cpu_bus.data_wr_n; endsequence
  sel_exclusive_a: assert property (
    !(!mem_sel.flash_ce_n && !mem_sel.ram_ce_n)) else $error("both selects low");
  idle_deselect_a: assert property (
    idle_s |=> mem_sel.flash_ce_n && mem_sel.ram_ce_n) else $error("select without strobe");
  flash_bank_a: assert property (
    !mem_sel.flash_ce_n |-> !mem_sel.mem_a16) else $error("flash with bank bit set");
  led_pair_a: assert property (led_red != led_green) else $error("leds agree");
  mode_held_a: assert property (
    (!$stable(led_red) || !$stable(led_green)) |-> since_evt < 4'd12)
    else $error("mode changed without reset");
  ready_after_a: assert property (setup_s |=> apb_rsp.pready) else $error("no pready");
  ready_pulse_a: assert property (answer_s |=> !apb_rsp.pready) else $error("pready held");
  rdata_zero_a: assert property (
    !apb_rsp.pready |-> apb_rsp.prdata == MDD_ZERO_WORD) else $error("stray read data");
  unmapped_err_a: assert property (
    setup_s ##0 !mapped |=> apb_rsp.pslverr && apb_rsp.pready) else $error("no slave error");
endmodule
bind mdd_decoder mdd_decoder_assertions chk_u (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .cpu_bus(cpu_bus), .mem_sel(mem_sel), .led_red(led_red), .led_green(led_green)
);

// ### verification/tb.sv
// Self-checking bench for the memory map and mode decoder
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb
  import mdd_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  mdd_apb_req_t apb_req = '0;
  mdd_apb_rsp_t apb_rsp;
  mdd_cpu_bus_t cpu_bus;
  logic [4:0] jmp_n = 5'h1F;
  logic [3:0] port_opt = 4'h0;
  logic sw = 1'b0;
  mdd_mem_sel_t mem_sel;
  logic led_red;
  logic led_green;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 53;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  // ********
  // Clock, watchdog and instances
  // ********
  always #50 pclk = ~pclk;
  // Whole run needs under 5000 cycles; a hang is cut off well after
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  mdd_decoder dut_u (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .cpu_bus(cpu_bus), .option_jumper_inputs_n(jmp_n),
    .port_driven_option_inputs(port_opt), .mode_slide_switch(sw),
    .mem_sel(mem_sel), .led_red(led_red), .led_green(led_green)
  );
  mdd_cpu_model cpu_u (.pclk(pclk), .cpu_bus(cpu_bus));
  // ********
  // Expectations and tasks
  // ********
  function automatic mdd_arch_t exp_arch(input logic [1:0] jn);
    case (~jn)
      2'b01: return MDD_RAM_RESIDENT_ARCH;
      2'b11: return MDD_OVERLAPPED_MONITOR_ARCH;
      default: return MDD_FLASH_CODE_ARCH;
    endcase
  endfunction
  function automatic mdd_mem_sel_t exp_sel(input mdd_arch_t a, input logic run,
                                           input logic [1:0] k, input logic [15:0] ad);
    mdd_mem_sel_t s;
    s = '{1'b1, 1'b1, 1'b0, ad[15]};
    if (a == MDD_FLASH_CODE_ARCH) begin
      s.flash_ce_n = (k != 2'd1);
      s.ram_ce_n = (k == 2'd1);
    end else if (a == MDD_RAM_RESIDENT_ARCH) begin
      s.ram_ce_n = 1'b0;
      s.mem_a16 = (k != 2'd1);
    end else begin
      s.flash_ce_n = (ad[15] != run);
      s.ram_ce_n = (ad[15] == run);
      s.mem_a15 = 1'b0;
    end
    return s;
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    apb_req <= '{a, 1'b1, 1'b0, wr, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // Ends once pready is seen; only a hang is left to the watchdog
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  // Selects are registered, so look one edge after the strobe is taken
  task automatic access(input mdd_arch_t a, input logic run, input logic [1:0] k,
                        input logic [15:0] ad);
    cpu_u.cycle(k, ad);
    @(posedge pclk);
    @(negedge pclk);
    if (k == 2'd0) begin
      `CHK({mem_sel.flash_ce_n, mem_sel.ram_ce_n}, 2'b11)
    end else begin
      `CHK(mem_sel, exp_sel(a, run, k, ad))
    end
  endtask
  task automatic restart();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task automatic summarize();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    logic [1:0] pats [4];
    int r;
    mdd_arch_t a;
    pats = '{2'b11, 2'b10, 2'b00, 2'b01};
    for (int p = 0; p < 4; p++) begin
      for (int m = 0; m < 2; m++) begin
        @(posedge pclk); // Pins change only on a rising edge
        r = $random(seed);
        jmp_n <= {r[4:2], pats[p]};
        port_opt <= r[11:8];
        sw <= m[0];
        restart();
        a = exp_arch(pats[p]);
        `CHK(led_red, ~m[0])
        `CHK(led_green, m[0])
        apb(1'b0, MDD_STATUS_OFS, MDD_ZERO_WORD);
        `CHK(rd[4:0], {m[0], 1'b0, a})
        access(a, m[0], 2'd1, 16'h0000);
        for (int i = 0; i < 24; i++) begin
          r = $random(seed);
          access(a, m[0], r[1:0], r[31:16]);
        end
        @(posedge pclk);
        sw <= ~m[0];
        repeat (10) @(posedge pclk);
        `CHK(led_green, m[0])
        access(a, m[0], 2'd1, 16'h8000);
      end
    end
    // Register corners: reset value, unmapped place, read-back
    apb(1'b0, MDD_CTRL_OFS, MDD_ZERO_WORD);
    `CHK(rd, MDD_ZERO_WORD)
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h010, MDD_ZERO_WORD);
    `CHK({err, rd}, {1'b1, MDD_ZERO_WORD})
    // Port options enabled plus recapture lands on the overlapped map
    port_opt <= 4'h3;
    apb(1'b1, MDD_CTRL_OFS, 32'h0000_0003);
    repeat (12) @(posedge pclk);
    apb(1'b0, MDD_STATUS_OFS, MDD_ZERO_WORD);
    `CHK(rd[4:0], {2'b00, MDD_OVERLAPPED_MONITOR_ARCH})
    `CHK(led_red, 1'b1)
    // Overlapped program map through the port inputs, then the other registers
    access(MDD_OVERLAPPED_MONITOR_ARCH, 1'b0, 2'd2, 16'h0000);
    apb(1'b0, MDD_MAP_OFS, MDD_ZERO_WORD);
    `CHK(rd[3:0], exp_sel(MDD_OVERLAPPED_MONITOR_ARCH, 1'b0, 2'd2, 16'h0000))
    apb(1'b0, MDD_CTRL_OFS, MDD_ZERO_WORD);
    `CHK(rd, 32'h0000_0001)
    // One latch after the last reset plus one recapture
    apb(1'b0, MDD_COUNT_OFS, MDD_ZERO_WORD);
    `CHK(rd[7:0], 8'h02)
    summarize();
  end
endmodule
